// [src/irq_pkg.sv]
// Purpose: Shared constants for the interrupt gating and wake vector block
// Assumes: 8-bit control, enable and flag registers (3-bit power control, 2-bit wake status), 13-bit program counter, APB byte offsets
// Notes:   Offsets are byte addresses of 32-bit aligned words
package irq_pkg;
  // Register offsets
  localparam logic [7:0] CORE_CTRL_OFS   = 8'h00;
  localparam logic [7:0] PERIPH_EN_OFS   = 8'h04;
  localparam logic [7:0] PERIPH_FLAG_OFS = 8'h08;
  localparam logic [7:0] POWER_CTRL_OFS  = 8'h0C;
  localparam logic [7:0] WAKE_STAT_OFS   = 8'h10;
  // Core control field positions
  localparam int GLOBAL_EN_BIT = 7;
  localparam int PEIE_BIT  = 6;
  localparam int T0IE_BIT  = 5;
  localparam int EXTIE_BIT = 4;
  localparam int PCIE_BIT  = 3;
  localparam int T0IF_BIT  = 2;
  localparam int EXTIF_BIT = 1;
  localparam int PCIF_BIT  = 0;
  // Wake status and power control field positions
  localparam int STAT_HI_BIT  = 4;
  localparam int STAT_LO_BIT  = 3;
  localparam int PWR_HI_BIT   = 2;
  localparam int PWR_BOR_BIT  = 0;
  // Reset values
  localparam logic [7:0] CORE_CTRL_RST   = 8'h00;
  localparam logic [7:0] PERIPH_EN_RST   = 8'h00;
  localparam logic [7:0] PERIPH_FLAG_RST = 8'h00;
  localparam logic [2:0] POWER_CTRL_POR  = 3'h4;
  localparam logic [1:0] STAT_POR        = 2'h3;
  // Program counter values
  localparam int         PC_W        = 13;
  localparam logic [12:0] RESET_ADDR  = 13'h0000;
  localparam logic [12:0] VECTOR_ADDR = 13'h0004;
  // Timing: clocks per instruction cycle, instruction cycles to vector
  localparam int         TCY_CLKS    = 4;
  localparam logic [1:0] LATENCY_TCY = 2'h3;
endpackage

// [src/irq_gating_and_wake_vector.sv]
// Purpose: Interrupt flag gathering, gating, vectoring, reset and wake PC/status effects
// Assumes: One 50 MHz clock; instruction cycle is an enable pulse every TCY_CLKS clocks
// Notes:   Registers reached over APB with one wait state; core obeys load and push pulses
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module irq_gating_and_wake_vector
  import irq_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire logic              extEdgeEvt,
  input  wire logic              timerZeroOvfEvt,
  input  wire logic              portChangeEvt,
  input  wire logic [7:0]        periphEvt,
  input  wire logic              returnFromIrq,
  input  wire logic              irqDisableInstr,
  input  wire logic              sleeping,
  input  wire logic [PC_W-1:0]   pcCurrent,
  input  wire logic              masterClearEvt,
  input  wire logic              watchdogTimeoutEvt,
  input  wire logic              borEvt,
  output logic                   irqRequest,
  output logic                   vectorTaken,
  output logic                   pushReturn,
  output logic                   pcLoad,
  output logic [PC_W-1:0]        pcValue,
  output logic                   wakeUp,
  output logic [1:0]             wakeStatus,
  output logic [2:0]             powerStatus
);

  // Any enabled flag with its own mask, peripherals gated by their group enable
  function automatic logic enabledPending(input logic [7:0] cc, input logic [7:0] pe,
                                          input logic [7:0] pf);
    enabledPending = (cc[T0IE_BIT] & cc[T0IF_BIT]) | (cc[EXTIE_BIT] & cc[EXTIF_BIT])
                   | (cc[PCIE_BIT] & cc[PCIF_BIT]) | (cc[PEIE_BIT] & |(pe & pf));
  endfunction

  logic [7:0]       coreCtrl_r, coreCtrl_nxt;
  logic [7:0]       periphEn_r, periphEn_nxt;
  logic [7:0]       periphFlag_r, periphFlag_nxt;
  logic [2:0]       powerCtrl_r, powerCtrl_nxt;
  logic [1:0]       wakeStat_r, wakeStat_nxt;
  logic [1:0]       tcyCnt_r, tcyCnt_nxt;
  logic             tcyTick;
  logic [1:0]       stage_r, stage_nxt;
  logic             wokeLatch_r, wokeLatch_nxt;
  logic             pready_r, pready_nxt;
  logic [31:0]      prdata_r, prdata_nxt;
  logic             pslverr_r, pslverr_nxt;
  logic             irqReq_r, irqReq_nxt;
  logic             vector_r, vector_nxt;
  logic             pcLoad_r, pcLoad_nxt;
  logic [PC_W-1:0]  pcValue_r, pcValue_nxt;
  logic             wake_r, wake_nxt;
  logic             wrDone;
  logic             mapped;
  logic             anyEnabled;
  logic             globalEnDrop;

  // Instruction-cycle enable from a free divider
  always_comb begin
    tcyCnt_nxt = (tcyCnt_r == 2'(TCY_CLKS - 1)) ? 2'h0 : tcyCnt_r + 2'h1;
  end
  assign tcyTick = (tcyCnt_r == 2'(TCY_CLKS - 1));

  // APB decode; a write lands only at the edge that completes the access
  assign wrDone = psel & penable & pready_r & pwrite;
  assign mapped = (paddr == CORE_CTRL_OFS) | (paddr == PERIPH_EN_OFS)
                | (paddr == PERIPH_FLAG_OFS) | (paddr == POWER_CTRL_OFS)
                | (paddr == WAKE_STAT_OFS);
  assign anyEnabled = enabledPending(coreCtrl_r, periphEn_r, periphFlag_r);
  // Software or core clearing a set global enable
  assign globalEnDrop = coreCtrl_r[GLOBAL_EN_BIT] & (irqDisableInstr
                      | (wrDone & (paddr == CORE_CTRL_OFS) & ~pwdata[GLOBAL_EN_BIT]));

  // Bus answer: one wait state so data come from flops
  always_comb begin
    pready_nxt  = psel & penable & ~pready_r;
    prdata_nxt  = prdata_r;
    pslverr_nxt = 1'b0;
    if (psel & penable & ~pready_r) begin
      pslverr_nxt = ~mapped;
      case (paddr)
        CORE_CTRL_OFS:   prdata_nxt = {24'h000000, coreCtrl_r};
        PERIPH_EN_OFS:   prdata_nxt = {24'h000000, periphEn_r};
        PERIPH_FLAG_OFS: prdata_nxt = {24'h000000, periphFlag_r};
        POWER_CTRL_OFS:  prdata_nxt = {29'h00000000, powerCtrl_r};
        WAKE_STAT_OFS:   prdata_nxt = {27'h0000000, wakeStat_r, 3'h0};
        default:         prdata_nxt = 32'h00000000;
      endcase
    end
  end

  // Flags, enables, reset and wake effects, vector sequencing
  always_comb begin
    coreCtrl_nxt   = coreCtrl_r;
    periphEn_nxt   = periphEn_r;
    periphFlag_nxt = periphFlag_r;
    powerCtrl_nxt  = powerCtrl_r;
    wakeStat_nxt   = wakeStat_r;
    stage_nxt      = stage_r;
    wokeLatch_nxt  = wokeLatch_r & sleeping;
    vector_nxt     = 1'b0;
    pcLoad_nxt     = 1'b0;
    pcValue_nxt    = pcValue_r;
    wake_nxt       = 1'b0;
    // Software writes first, so hardware sets below win over a clear
    if (wrDone) begin
      case (paddr)
        CORE_CTRL_OFS:   coreCtrl_nxt = pwdata[7:0];
        PERIPH_EN_OFS:   periphEn_nxt = pwdata[7:0];
        PERIPH_FLAG_OFS: periphFlag_nxt = pwdata[7:0];
        POWER_CTRL_OFS:  powerCtrl_nxt = pwdata[2:0];
        default:         ;
      endcase
    end
    if (irqDisableInstr)
      coreCtrl_nxt[GLOBAL_EN_BIT] = 1'b0;
    if (returnFromIrq)
      coreCtrl_nxt[GLOBAL_EN_BIT] = 1'b1;
    // Event latching ignores every enable
    if (extEdgeEvt)
      coreCtrl_nxt[EXTIF_BIT] = 1'b1;
    if (timerZeroOvfEvt)
      coreCtrl_nxt[T0IF_BIT] = 1'b1;
    if (portChangeEvt)
      coreCtrl_nxt[PCIF_BIT] = 1'b1;
    periphFlag_nxt = periphFlag_nxt | periphEvt;
    // Latency counted in instruction ticks only, never in instruction length
    if (globalEnDrop | ~coreCtrl_r[GLOBAL_EN_BIT] | ~anyEnabled | sleeping) begin
      stage_nxt = 2'h0;
    end else if (tcyTick) begin
      if (stage_r == LATENCY_TCY - 2'h1) begin
        stage_nxt             = 2'h0;
        vector_nxt            = 1'b1;
        pcLoad_nxt            = 1'b1;
        pcValue_nxt           = VECTOR_ADDR;
        coreCtrl_nxt[GLOBAL_EN_BIT] = 1'b0;
      end else begin
        stage_nxt = stage_r + 2'h1;
      end
    end
    // Wake from sleep: resume at PC+1, flags kept for polling
    if (sleeping & anyEnabled & ~wokeLatch_r) begin
      wake_nxt      = 1'b1;
      wokeLatch_nxt = 1'b1;
      pcLoad_nxt    = 1'b1;
      pcValue_nxt   = pcCurrent + PC_W'(1);
      wakeStat_nxt  = 2'h2;
    end
    // External resets, highest first
    if (borEvt | masterClearEvt | (watchdogTimeoutEvt & ~sleeping)) begin
      coreCtrl_nxt   = CORE_CTRL_RST;
      periphEn_nxt   = PERIPH_EN_RST;
      periphFlag_nxt = PERIPH_FLAG_RST;
      stage_nxt      = 2'h0;
      vector_nxt     = 1'b0;
      wake_nxt       = 1'b0;
      pcLoad_nxt     = 1'b1;
      pcValue_nxt    = RESET_ADDR;
      if (borEvt) begin
        wakeStat_nxt               = STAT_POR;
        powerCtrl_nxt[PWR_HI_BIT]  = 1'b1;
        powerCtrl_nxt[PWR_BOR_BIT] = 1'b0;
      end else if (masterClearEvt) begin
        if (sleeping)
          wakeStat_nxt = 2'h2;
        else
          wakeStat_nxt = wakeStat_r;
      end else begin
        wakeStat_nxt = 2'h0;
      end
    end else if (watchdogTimeoutEvt & sleeping) begin
      wake_nxt      = 1'b1;
      wokeLatch_nxt = 1'b1;
      pcLoad_nxt    = 1'b1;
      pcValue_nxt   = pcCurrent + PC_W'(1);
      wakeStat_nxt  = 2'h0;
    end
  end

  // Request line follows the next-state view so it tracks writes promptly
  always_comb begin
    irqReq_nxt = coreCtrl_nxt[GLOBAL_EN_BIT]
               & enabledPending(coreCtrl_nxt, periphEn_nxt, periphFlag_nxt);
  end

  // State registers; the synchronous reset acts as power-on
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tcyCnt_r     <= 2'h0;
      coreCtrl_r   <= CORE_CTRL_RST;
      periphEn_r   <= PERIPH_EN_RST;
      periphFlag_r <= PERIPH_FLAG_RST;
      powerCtrl_r  <= POWER_CTRL_POR;
      wakeStat_r   <= STAT_POR;
      stage_r      <= 2'h0;
      wokeLatch_r  <= 1'b0;
      pready_r     <= 1'b0;
      prdata_r     <= 32'h00000000;
      pslverr_r    <= 1'b0;
      irqReq_r     <= 1'b0;
      vector_r     <= 1'b0;
      pcLoad_r     <= 1'b1;
      pcValue_r    <= RESET_ADDR;
      wake_r       <= 1'b0;
    end else begin
      tcyCnt_r     <= tcyCnt_nxt;
      coreCtrl_r   <= coreCtrl_nxt;
      periphEn_r   <= periphEn_nxt;
      periphFlag_r <= periphFlag_nxt;
      powerCtrl_r  <= powerCtrl_nxt;
      wakeStat_r   <= wakeStat_nxt;
      stage_r      <= stage_nxt;
      wokeLatch_r  <= wokeLatch_nxt;
      pready_r     <= pready_nxt;
      prdata_r     <= prdata_nxt;
      pslverr_r    <= pslverr_nxt;
      irqReq_r     <= irqReq_nxt;
      vector_r     <= vector_nxt;
      pcLoad_r     <= pcLoad_nxt;
      pcValue_r    <= pcValue_nxt;
      wake_r       <= wake_nxt;
    end
  end

  // Outputs straight from flops
  assign pready      = pready_r;
  assign prdata      = prdata_r;
  assign pslverr     = pslverr_r;
  assign irqRequest  = irqReq_r;
  assign vectorTaken = vector_r;
  assign pushReturn  = vector_r;
  assign pcLoad      = pcLoad_r;
  assign pcValue     = pcValue_r;
  assign wakeUp      = wake_r;
  assign wakeStatus  = wakeStat_r;
  assign powerStatus = powerCtrl_r;

  // Reset events as the checks see them; a watchdog timeout while awake is a reset
  logic anyResetEvt;
  assign anyResetEvt = borEvt | masterClearEvt | (watchdogTimeoutEvt & ~sleeping);

  // Checks on the block's own registers and outputs
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Pin edge flag follows its event
  a_flag_sets_always: assert property (extEdgeEvt |=> coreCtrl_r[EXTIF_BIT])
    else $error("pin edge flag not set");
  // One peripheral flag as a sample of the group
  a_periph_flag_set: assert property (periphEvt[3] |=> periphFlag_r[3])
    else $error("peripheral flag not set");
  // Port change flag lives in core control; a reset beside it clears it
  a_port_flag_set: assert property (portChangeEvt && !anyResetEvt |=> coreCtrl_r[PCIF_BIT])
    else $error("port change flag not set");
  // Timer zero flag lives in core control too
  a_timer_flag_set: assert property (timerZeroOvfEvt && !anyResetEvt |=> coreCtrl_r[T0IF_BIT])
    else $error("timer zero flag not set");

  // Vector: clear, push and load together
  a_vector_clears_enable: assert property (vector_r |-> !coreCtrl_r[GLOBAL_EN_BIT]
    && pushReturn && pcLoad && pcValue == VECTOR_ADDR)
    else $error("vector without clear, push or address");
  // Only a globally enabled block vectors
  a_vector_needs_enable: assert property (vector_r |-> $past(coreCtrl_r[GLOBAL_EN_BIT]))
    else $error("vector while globally disabled");
  // Enable falls with the vector, so it can never last two cycles
  a_vector_single: assert property (vector_r |=> !vector_r)
    else $error("vector held for two cycles");
  // Asleep the core waits for the wake pulse before any vector
  a_no_vector_asleep: assert property (sleeping |=> !vector_r)
    else $error("vector while asleep");

  // Request line gating
  a_request_gating: assert property (irqRequest |-> coreCtrl_r[GLOBAL_EN_BIT]
    && enabledPending(coreCtrl_r, periphEn_r, periphFlag_r))
    else $error("request without enabled flag");
  // Global enable low silences the request line
  a_disabled_quiet: assert property (!coreCtrl_r[GLOBAL_EN_BIT] |-> !irqRequest)
    else $error("request while globally disabled");
  // All sources masked leaves the request low whatever flags stand
  a_masked_source: assert property (!coreCtrl_r[EXTIE_BIT] && !coreCtrl_r[T0IE_BIT]
    && !coreCtrl_r[PCIE_BIT] && (periphEn_r & periphFlag_r) == 8'h00 |-> !irqRequest)
    else $error("request from a masked source");
  // Dropping the enable restarts the count and keeps requests pending
  a_enable_drop_holds: assert property (globalEnDrop && !returnFromIrq |=> !vector_r
    && stage_r == 2'h0)
    else $error("vector after global enable cleared");
  // Return sets the enable unless a reset or a vector lands in the same cycle
  a_return_sets_enable: assert property (returnFromIrq && !borEvt && !masterClearEvt
    && !watchdogTimeoutEvt |=> coreCtrl_r[GLOBAL_EN_BIT])
    else $error("return did not set global enable");

  // Brown-out clears the enable, loads zero and marks power control
  a_reset_clears_enable: assert property (borEvt |=> !coreCtrl_r[GLOBAL_EN_BIT]
    && pcLoad && pcValue == RESET_ADDR && powerStatus[2] && !powerStatus[0])
    else $error("brown-out effects missing");
  // Master clear clears the enable and restarts at zero
  a_clear_reset_pc: assert property (masterClearEvt && !borEvt |=>
    !coreCtrl_r[GLOBAL_EN_BIT] && pcLoad && pcValue == RESET_ADDR)
    else $error("master clear effects missing");
  // Master clear leaves power control as it was
  a_power_kept: assert property (masterClearEvt && !borEvt && !wrDone |=>
    powerStatus == $past(powerStatus))
    else $error("power control changed by master clear");
  // Brown-out status pattern and disabled interrupts
  a_brownout_status: assert property (borEvt |=> wakeStatus == STAT_POR
    && !coreCtrl_r[GLOBAL_EN_BIT])
    else $error("brown-out status wrong");

  // Interrupt wake: status pattern and resume address
  a_wake_status: assert property (wake_r && !$past(watchdogTimeoutEvt) |->
    wakeStatus == 2'h2 && pcValue == $past(pcCurrent) + PC_W'(1))
    else $error("interrupt wake status or pc wrong");
  // Watchdog wake resumes at the next address with both status bits low
  a_watchdog_wake: assert property (watchdogTimeoutEvt && sleeping && !borEvt
    && !masterClearEvt |=> wakeUp && wakeStatus == 2'h0 && pcValue == $past(pcCurrent) + PC_W'(1))
    else $error("watchdog wake effects wrong");
  // The cause of an interrupt wake stays visible for polling
  a_wake_flags_kept: assert property (wake_r && wakeStatus == 2'h2 |->
    coreCtrl_r[T0IF_BIT] || coreCtrl_r[EXTIF_BIT] || coreCtrl_r[PCIF_BIT] || periphFlag_r != 8'h00)
    else $error("wake cause flag missing");

  // Counted from a qualifying tick at stage zero: the third tick lands eight cycles on
  a_latency_bound: assert property (coreCtrl_r[GLOBAL_EN_BIT] && anyEnabled
    && !sleeping && stage_r == 2'h0 && tcyTick && !globalEnDrop && !returnFromIrq
    && !anyResetEvt && !wrDone ##1 (coreCtrl_r[GLOBAL_EN_BIT] && anyEnabled && !sleeping
    && !globalEnDrop && !wrDone && !anyResetEvt) [*8] |=> vector_r)
    else $error("vector later than three instruction cycles");

  // Main scenarios
  c_vector: cover property (vector_r);
  c_int_wake: cover property (wake_r && wakeStatus == 2'h2);
  c_watchdog_wake: cover property (wake_r && wakeStatus == 2'h0);
  c_suppressed: cover property (globalEnDrop && stage_r != 2'h0);
  c_brownout: cover property (borEvt ##1 pcLoad);

endmodule

// [sim/core_model.sv]
// Purpose: Behavioural core fetch and stack model facing the interrupt block
// Assumes: PC advances once per four clocks while awake; halts while asleep
// Notes:   Sleep is requested by the bench; wake pulse ends it
`timescale 1ns/1ps
module core_model (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        pcLoad,
  input  wire logic [12:0] pcValue,
  input  wire logic        pushReturn,
  input  wire logic        wakeUp,
  input  wire logic        sleepReq,
  output logic      [12:0] pcCurrent,
  output logic             sleeping,
  output logic      [12:0] stackTop
);
  logic [1:0] div_r;
  // Fetch, stack and sleep state; PC frozen in sleep so PC+1 is predictable
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pcCurrent <= 13'h0000;
      sleeping  <= 1'b0;
      div_r     <= 2'h0;
      stackTop  <= 13'h0000;
    end else begin
      div_r <= div_r + 2'h1;
      if (pcLoad) begin
        pcCurrent <= pcValue;
      end else if (!sleeping && div_r == 2'h3) begin
        pcCurrent <= pcCurrent + 13'h0001;
      end
      if (pushReturn) begin
        stackTop <= pcCurrent;
      end
      if (wakeUp) begin
        sleeping <= 1'b0;
      end else if (sleepReq) begin
        sleeping <= 1'b1;
      end
    end
  end
endmodule

// [sim/irq_gating_and_wake_vector_tb.sv]
// Purpose: Self-checking bench for interrupt gating, vectoring and wake effects
// Assumes: One wait state APB slave; event inputs are one-cycle pulses
// Notes:   Vector latency window allows for the free-running instruction divider
`timescale 1ns/1ps
module irq_gating_and_wake_vector_tb;
  import irq_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rdv;
  logic pready, pslverr, err, irqRequest, vectorTaken, pushReturn, pcLoad, wakeUp;
  logic extEdgeEvt = 0, timerZeroOvfEvt = 0, portChangeEvt = 0, returnFromIrq = 0;
  logic irqDisableInstr = 0, masterClearEvt = 0, watchdogTimeoutEvt = 0, borEvt = 0;
  logic sleepReq = 0;
  logic [7:0] periphEvt = 8'h00;
  logic [31:0] prdata;
  logic [12:0] pcCurrent, pcValue, stackTop, pcSaved, pv;
  logic sleeping, got, pr, wu, vt;
  logic [1:0] wakeStatus, ws;
  logic [2:0] powerStatus;
  int n_mismatch = 0, cmp_count = 0, n;
  localparam logic [15:0] EXT = 16'h0100, T0 = 16'h0200, PORT = 16'h0400, RET = 16'h0800;
  localparam logic [15:0] GCLR = 16'h1000, MCLEAR = 16'h2000, WDOG = 16'h4000, BOR = 16'h8000;

  always #10 clk = ~clk;

  irq_gating_and_wake_vector DUT (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .extEdgeEvt(extEdgeEvt),
    .timerZeroOvfEvt(timerZeroOvfEvt), .portChangeEvt(portChangeEvt), .periphEvt(periphEvt),
    .returnFromIrq(returnFromIrq), .irqDisableInstr(irqDisableInstr), .sleeping(sleeping),
    .pcCurrent(pcCurrent), .masterClearEvt(masterClearEvt),
    .watchdogTimeoutEvt(watchdogTimeoutEvt), .borEvt(borEvt),
    .irqRequest(irqRequest), .vectorTaken(vectorTaken), .pushReturn(pushReturn),
    .pcLoad(pcLoad), .pcValue(pcValue), .wakeUp(wakeUp), .wakeStatus(wakeStatus),
    .powerStatus(powerStatus));

  core_model core (.clk(clk), .reset_n(reset_n), .pcLoad(pcLoad), .pcValue(pcValue),
    .pushReturn(pushReturn), .wakeUp(wakeUp), .sleepReq(sleepReq), .pcCurrent(pcCurrent),
    .sleeping(sleeping), .stackTop(stackTop));

  task close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // APB transfer; request held until pready is sampled high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 20);
    rdv = prdata;
    err = pslverr;
    // Release, then one idle cycle so the next call never re-drives psel in this step
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin n_mismatch++; $display("APB timeout"); close_out(); end
    @(posedge clk);
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    check(rdv, {24'h0, e});
  endtask

  // One-cycle pulses; a shared vector keeps each pulse to one set and one clear
  task pulse(input logic [15:0] v);
    {borEvt, watchdogTimeoutEvt, masterClearEvt, irqDisableInstr, returnFromIrq,
     portChangeEvt, timerZeroOvfEvt, extEdgeEvt, periphEvt} <= v;
    @(posedge clk);
    {borEvt, watchdogTimeoutEvt, masterClearEvt, irqDisableInstr, returnFromIrq,
     portChangeEvt, timerZeroOvfEvt, extEdgeEvt, periphEvt} <= 16'h0000;
  endtask

  // Bounded wait for a PC load; captures the outputs that go with it
  task wait_load(input int lim, input bit must);
    n = 0;
    do begin @(posedge clk); n++; end while (pcLoad !== 1'b1 && n < lim);
    got = (pcLoad === 1'b1);
    pv = pcValue;
    pr = pushReturn;
    vt = vectorTaken;
    wu = wakeUp;
    ws = wakeStatus;
    if (must && !got) begin n_mismatch++; $display("wait timeout"); close_out(); end
  endtask

  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    check(pcValue, RESET_ADDR);
    rd(CORE_CTRL_OFS, 8'h00);
    rd(PERIPH_FLAG_OFS, 8'h00);
    rd(POWER_CTRL_OFS, 8'h04);
    rd(WAKE_STAT_OFS, 8'h18);
    rd(8'h14, 8'h00);
    check(err, 1'b1);
    $display("reset values done");
    pulse(EXT | T0 | PORT | 16'h00FF);
    rd(CORE_CTRL_OFS, 8'h07);
    rd(PERIPH_FLAG_OFS, 8'hFF);
    wr(CORE_CTRL_OFS, 8'h7F);
    wr(PERIPH_EN_OFS, 8'hFF);
    wait_load(30, 0);
    check(got, 1'b0);
    check(irqRequest, 1'b0);
    wr(CORE_CTRL_OFS, 8'h78);
    wr(PERIPH_FLAG_OFS, 8'h00);
    wr(PERIPH_EN_OFS, 8'h04);
    pulse(16'h0008);
    wr(CORE_CTRL_OFS, 8'hC0);
    check(irqRequest, 1'b0);
    wr(PERIPH_EN_OFS, 8'h08);
    repeat (2) @(posedge clk);
    check(irqRequest, 1'b1);
    wait_load(20, 1);
    check(pv, VECTOR_ADDR);
    check(pr, 1'b1);
    check(vt, 1'b1);
    rd(CORE_CTRL_OFS, 8'h40);
    pulse(RET);
    wait_load(20, 1);
    check(pv, VECTOR_ADDR);
    wr(PERIPH_FLAG_OFS, 8'h00);
    pulse(RET);
    wait_load(30, 0);
    check(got, 1'b0);
    rd(CORE_CTRL_OFS, 8'hC0);
    $display("gating and masking done");
    wr(PERIPH_EN_OFS, 8'h00);
    wr(CORE_CTRL_OFS, 8'h90);
    pulse(EXT);
    wait_load(20, 1);
    check(n >= 9 && n <= 13, 1'b1);
    rd(CORE_CTRL_OFS, 8'h12);
    pulse(RET);
    @(posedge clk);
    pulse(GCLR);
    wait_load(30, 0);
    check(got, 1'b0);
    rd(CORE_CTRL_OFS, 8'h12);
    pulse(RET);
    wait_load(20, 1);
    check(pv, VECTOR_ADDR);
    $display("latency and suppression done");
    wr(CORE_CTRL_OFS, 8'h10);
    sleepReq <= 1'b1;
    @(posedge clk);
    sleepReq <= 1'b0;
    repeat (2) @(posedge clk);
    pcSaved = pcCurrent;
    pulse(EXT);
    wait_load(5, 1);
    check(wu, 1'b1);
    check(pv, pcSaved + 13'h0001);
    check(ws, 2'b10);
    wait_load(30, 0);
    check(got, 1'b0);
    rd(CORE_CTRL_OFS, 8'h12);
    wr(CORE_CTRL_OFS, 8'h90);
    sleepReq <= 1'b1;
    @(posedge clk);
    sleepReq <= 1'b0;
    pulse(EXT);
    wait_load(5, 1);
    check(wu, 1'b1);
    wait_load(30, 1);
    check(pv, VECTOR_ADDR);
    $display("interrupt wake done");
    wr(CORE_CTRL_OFS, 8'h00);
    sleepReq <= 1'b1;
    @(posedge clk);
    sleepReq <= 1'b0;
    repeat (2) @(posedge clk);
    pcSaved = pcCurrent;
    pulse(WDOG);
    wait_load(5, 1);
    check(pv, pcSaved + 13'h0001);
    check(ws, 2'b00);
    pulse(WDOG);
    wait_load(5, 1);
    check(pv, RESET_ADDR);
    wr(POWER_CTRL_OFS, 8'h03);
    wr(CORE_CTRL_OFS, 8'h80);
    pulse(BOR);
    wait_load(5, 1);
    check(pv, RESET_ADDR);
    check(ws, 2'b11);
    check(powerStatus, 3'b110);
    rd(CORE_CTRL_OFS, 8'h00);
    wr(CORE_CTRL_OFS, 8'h80);
    pulse(MCLEAR);
    wait_load(5, 1);
    check(pv, RESET_ADDR);
    rd(CORE_CTRL_OFS, 8'h00);
    rd(POWER_CTRL_OFS, 8'h06);
    $display("watchdog and resets done");
    close_out();
  end
endmodule
